// ### hdl/tcrb_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcrb_cfg.svh"
module tcrb_bank
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Asynchronous pins
  input wire logic demod_pin_a,
  input wire logic demod_pin_b,
  input wire logic lowbat_sense,
  // Wide timer link
  input wire logic [15:0] wide_cap_value,
  input wire logic wide_cap_strobe,
  output logic [15:0] wide_hold,
  output logic [7:0] common_ctl,
  output logic [7:0] wide_ctl,
  // Pin routing
  input wire logic port_bit,
  output logic pin_out,
  output logic narrow_out,
  // Interrupt requests
  input wire logic int_five_enable,
  output logic int_five_req,
  output logic timeout_irq,
  output logic capture_irq
);
  tcrb_pkg::tcrb_byte_t ctl_reg, ctl_next, cctl_reg, cctl_next, wctl_reg, wctl_next;
  tcrb_pkg::tcrb_byte_t nhl_reg, nhl_next, nhh_reg, nhh_next, cnt_reg, cnt_next;
  tcrb_pkg::tcrb_byte_t ncl_reg, ncl_next, nch_reg, nch_next, rd_reg, rd_next;
  logic [15:0] wh_reg, wh_next, wc_reg, wc_next;
  tcrb_pkg::tcrb_lvl_t lvl_reg, lvl_next;
  logic lb_en_reg, lb_en_next, lb_flag_reg, lb_flag_next;
  logic pin_reg, pin_next, tirq_reg, tirq_next, cirq_reg, cirq_next;
  logic i5_reg, i5_next, dm_prev_reg, dm_prev_next;
  logic [2:0] sy1_reg, sy2_reg;
  logic tick, dm_now, rise, fall, edge_hit, term_evt, cap_evt, run;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sy1_reg <= 3'h0;
      sy2_reg <= 3'h0;
    end
    else if (ce)
    begin
      sy1_reg <= {lowbat_sense, demod_pin_b, demod_pin_a};
      sy2_reg <= sy1_reg;
    end
  end

  // ==========================================================
  // Count clock divider
  tcrb_prescale u_pre
  (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .sel(ctl_reg[`TCRB_NCTL_PRE_HI:`TCRB_NCTL_PRE_LO]),
    .tick(tick)
  );

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    ctl_next = ctl_reg;
    cctl_next = cctl_reg;
    wctl_next = wctl_reg;
    nhl_next = nhl_reg;
    nhh_next = nhh_reg;
    wh_next = wh_reg;
    cnt_next = cnt_reg;
    ncl_next = ncl_reg;
    nch_next = nch_reg;
    wc_next = wc_reg;
    lvl_next = lvl_reg;
    lb_en_next = lb_en_reg;
    run = ctl_reg[`TCRB_NCTL_RUN];
    dm_now = cctl_reg[`TCRB_CCTL_INSEL] ? sy2_reg[1] : sy2_reg[0];
    dm_prev_next = dm_now;
    rise = dm_now & ~dm_prev_reg;
    fall = ~dm_now & dm_prev_reg;
    unique case (cctl_reg[`TCRB_CCTL_EDGE_HI:`TCRB_CCTL_EDGE_LO])
      `TCRB_EDGE_FALL: edge_hit = fall;
      `TCRB_EDGE_RISE: edge_hit = rise;
      `TCRB_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
    term_evt = 1'b0;
    cap_evt = 1'b0;
    // Narrow timer
    if (run && cctl_reg[`TCRB_CCTL_MODE])
    begin
      if (edge_hit)
      begin
        cap_evt = 1'b1;
        cnt_next = `TCRB_RST_BYTE;
        if (fall)
          nch_next = cnt_reg;
        else
          ncl_next = cnt_reg;
      end
      else if (tick)
      begin
        cnt_next = cnt_reg + 8'h01;
        term_evt = (cnt_reg == `TCRB_CNT_TOP);
      end
    end
    else if (run && tick)
    begin
      if (cnt_reg == `TCRB_RST_BYTE)
      begin
        term_evt = 1'b1;
        unique case (lvl_reg)
          tcrb_pkg::TCRB_LVL_HIGH:
          begin
            lvl_next = tcrb_pkg::TCRB_LVL_LOW;
            cnt_next = nhl_reg;
          end
          tcrb_pkg::TCRB_LVL_LOW:
          begin
            lvl_next = tcrb_pkg::TCRB_LVL_HIGH;
            cnt_next = nhh_reg;
          end
        endcase
      end
      else
        cnt_next = cnt_reg - 8'h01;
    end
    if (term_evt && ctl_reg[`TCRB_NCTL_SINGLE])
      ctl_next[`TCRB_NCTL_RUN] = 1'b0;
    if (wide_cap_strobe)
      wc_next = wide_cap_value;
    // Register writes, capture locations take none
    if (reg_wr)
    begin
      case (reg_addr)
        `TCRB_OFS_NCTL:
        begin
          ctl_next = {reg_wdata[7:6], ctl_reg[5] & ~reg_wdata[5], reg_wdata[4:0]};
          if (reg_wdata[`TCRB_NCTL_RUN] && !run)
          begin
            cnt_next = cctl_reg[`TCRB_CCTL_MODE] ? `TCRB_RST_BYTE : nhh_reg;
            lvl_next = tcrb_pkg::TCRB_LVL_HIGH;
          end
        end
        `TCRB_OFS_CCTL: cctl_next = reg_wdata;
        `TCRB_OFS_WCTL: wctl_next = reg_wdata;
        `TCRB_OFS_NHOLD_LO: nhl_next = reg_wdata;
        `TCRB_OFS_NHOLD_HI: nhh_next = reg_wdata;
        `TCRB_OFS_WHOLD_LO: wh_next[7:0] = reg_wdata;
        `TCRB_OFS_WHOLD_HI: wh_next[15:8] = reg_wdata;
        `TCRB_OFS_LOWBAT: lb_en_next = reg_wdata[`TCRB_LOWBAT_EN];
        default: ;
      endcase
    end
    if (term_evt)
      ctl_next[`TCRB_NCTL_TMO] = 1'b1;
    lb_flag_next = lb_en_reg & sy2_reg[2];
    i5_next = lb_flag_next & int_five_enable;
    tirq_next = ctl_next[`TCRB_NCTL_TMO] & ctl_next[`TCRB_NCTL_TMOMSK];
    cirq_next = cap_evt & ctl_reg[`TCRB_NCTL_CAPMSK];
    pin_next = ctl_reg[`TCRB_NCTL_ROUTE] ? (lvl_reg == tcrb_pkg::TCRB_LVL_HIGH) : port_bit;
    // Read data, reserved and unmapped read zero
    case (reg_addr)
      `TCRB_OFS_NCTL: rd_next = ctl_reg;
      `TCRB_OFS_CCTL: rd_next = cctl_reg;
      `TCRB_OFS_WCTL: rd_next = wctl_reg;
      `TCRB_OFS_NHOLD_LO: rd_next = nhl_reg;
      `TCRB_OFS_NHOLD_HI: rd_next = nhh_reg;
      `TCRB_OFS_WHOLD_LO: rd_next = wh_reg[7:0];
      `TCRB_OFS_WHOLD_HI: rd_next = wh_reg[15:8];
      `TCRB_OFS_WCAP_LO: rd_next = wc_reg[7:0];
      `TCRB_OFS_WCAP_HI: rd_next = wc_reg[15:8];
      `TCRB_OFS_NCAP_LO: rd_next = ncl_reg;
      `TCRB_OFS_NCAP_HI: rd_next = nch_reg;
      `TCRB_OFS_LOWBAT: rd_next = {6'h00, lb_flag_reg, lb_en_reg};
      default: rd_next = `TCRB_RST_BYTE;
    endcase
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_reg <= `TCRB_RST_BYTE;
      cctl_reg <= `TCRB_RST_BYTE;
      wctl_reg <= `TCRB_RST_BYTE;
      nhl_reg <= `TCRB_RST_BYTE;
      nhh_reg <= `TCRB_RST_BYTE;
      wh_reg <= `TCRB_RST_WORD;
      cnt_reg <= `TCRB_RST_BYTE;
      ncl_reg <= `TCRB_RST_BYTE;
      nch_reg <= `TCRB_RST_BYTE;
      wc_reg <= `TCRB_RST_WORD;
      rd_reg <= `TCRB_RST_BYTE;
      lvl_reg <= tcrb_pkg::TCRB_LVL_LOW;
      lb_en_reg <= 1'b0;
      lb_flag_reg <= 1'b0;
      dm_prev_reg <= 1'b0;
      pin_reg <= 1'b0;
      tirq_reg <= 1'b0;
      cirq_reg <= 1'b0;
      i5_reg <= 1'b0;
    end
    else if (ce)
    begin
      ctl_reg <= ctl_next;
      cctl_reg <= cctl_next;
      wctl_reg <= wctl_next;
      nhl_reg <= nhl_next;
      nhh_reg <= nhh_next;
      wh_reg <= wh_next;
      cnt_reg <= cnt_next;
      ncl_reg <= ncl_next;
      nch_reg <= nch_next;
      wc_reg <= wc_next;
      rd_reg <= rd_next;
      lvl_reg <= lvl_next;
      lb_en_reg <= lb_en_next;
      lb_flag_reg <= lb_flag_next;
      dm_prev_reg <= dm_prev_next;
      pin_reg <= pin_next;
      tirq_reg <= tirq_next;
      cirq_reg <= cirq_next;
      i5_reg <= i5_next;
    end
  end

  assign reg_rdata = rd_reg;
  assign wide_hold = wh_reg;
  assign common_ctl = cctl_reg;
  assign wide_ctl = wctl_reg;
  assign pin_out = pin_reg;
  assign narrow_out = (lvl_reg == tcrb_pkg::TCRB_LVL_HIGH);
  assign int_five_req = i5_reg;
  assign timeout_irq = tirq_reg;
  assign capture_irq = cirq_reg;

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  lowbat_rsvd_a: assert property (ce && reg_addr == `TCRB_OFS_LOWBAT |=> reg_rdata[7:2] == 6'h00)
    else $error("Low battery reserved bits not zero");
  lowbat_flag_a: assert property ($rose(lb_flag_reg) |-> $past(lb_en_reg))
    else $error("Flag set while detection disabled");
  int_five_a: assert property (ce && lb_flag_next && int_five_enable |=> int_five_req)
    else $error("Interrupt five not raised");
  cap_hi_ro_a: assert property (ce && reg_wr && !cap_evt |=> $stable(nch_reg))
    else $error("High capture changed without capture");
  cap_lo_ro_a: assert property (ce && reg_wr && !cap_evt |=> $stable(ncl_reg))
    else $error("Low capture changed without capture");
  wide_cap_ro_a: assert property (ce && !wide_cap_strobe |=> $stable(wc_reg))
    else $error("Wide capture changed without strobe");
  hold_write_a: assert property (ce && reg_wr && reg_addr == `TCRB_OFS_NHOLD_HI
    |=> nhh_reg == $past(reg_wdata))
    else $error("High hold not written");
  run_start_a: assert property (ce && reg_wr && reg_addr == `TCRB_OFS_NCTL && reg_wdata[7]
    |=> ctl_reg[`TCRB_NCTL_RUN] ##1 (!$past(ce) || reg_rdata[7] || !$past(reg_addr == 4'h0)))
    else $error("Run bit not set by write");
  tmo_set_wins_a: assert property (ce && term_evt |=> ctl_reg[`TCRB_NCTL_TMO])
    else $error("Timeout flag lost");
  tmo_irq_a: assert property (timeout_irq |-> ctl_reg[`TCRB_NCTL_TMO] && ctl_reg[`TCRB_NCTL_TMOMSK])
    else $error("Timeout request without flag and mask");
  route_a: assert property (ce |=> pin_out == $past(ctl_reg[0] ? narrow_out : port_bit))
    else $error("Pin routing wrong");

  modulo_cov: cover property (ce && term_evt && !ctl_reg[`TCRB_NCTL_SINGLE]);
  capture_cov: cover property (capture_irq);
  lowbat_cov: cover property ($rose(int_five_req));
endmodule // tcrb_bank
`default_nettype wire

// ### hdl/tcrb_cfg.svh
`ifndef TCRB_CFG_SVH
`define TCRB_CFG_SVH
// ==========================================================
// Register offsets
`define TCRB_OFS_NCTL 4'h0
`define TCRB_OFS_CCTL 4'h1
`define TCRB_OFS_WCTL 4'h2
`define TCRB_OFS_RSVD 4'h3
`define TCRB_OFS_NHOLD_LO 4'h4
`define TCRB_OFS_NHOLD_HI 4'h5
`define TCRB_OFS_WHOLD_LO 4'h6
`define TCRB_OFS_WHOLD_HI 4'h7
`define TCRB_OFS_WCAP_LO 4'h8
`define TCRB_OFS_WCAP_HI 4'h9
`define TCRB_OFS_NCAP_LO 4'ha
`define TCRB_OFS_NCAP_HI 4'hb
`define TCRB_OFS_LOWBAT 4'hc
// ==========================================================
// Narrow timer control fields
`define TCRB_NCTL_RUN 7
`define TCRB_NCTL_SINGLE 6
`define TCRB_NCTL_TMO 5
`define TCRB_NCTL_PRE_HI 4
`define TCRB_NCTL_PRE_LO 3
`define TCRB_NCTL_CAPMSK 2
`define TCRB_NCTL_TMOMSK 1
`define TCRB_NCTL_ROUTE 0
// ==========================================================
// Common control and low battery fields
`define TCRB_CCTL_MODE 7
`define TCRB_CCTL_INSEL 6
`define TCRB_CCTL_EDGE_HI 5
`define TCRB_CCTL_EDGE_LO 4
`define TCRB_LOWBAT_EN 0
`define TCRB_LOWBAT_FLAG 1
// ==========================================================
// Reset values and edge codes
`define TCRB_RST_BYTE 8'h00
`define TCRB_RST_WORD 16'h0000
`define TCRB_CNT_TOP 8'hff
`define TCRB_EDGE_FALL 2'h0
`define TCRB_EDGE_RISE 2'h1
`define TCRB_EDGE_BOTH 2'h2
`endif

// ### hdl/tcrb_pkg.sv
`default_nettype none
package tcrb_pkg;
  typedef logic [7:0] tcrb_byte_t;
  typedef enum logic {TCRB_LVL_LOW, TCRB_LVL_HIGH} tcrb_lvl_t;
endpackage
`default_nettype wire

// ### hdl/tcrb_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tcrb_prescale
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Divider select and tick
  input wire logic [1:0] sel,
  output logic tick
);
  logic [2:0] div_reg;
  logic [2:0] div_next;

  // ==========================================================
  // Free-running divider
  always_comb
  begin
    div_next = div_reg + 3'h1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_reg <= 3'h0;
    else if (ce)
      div_reg <= div_next;
  end

  // Free-running phase gives a short first period
  always_comb
  begin
    unique case (sel)
      2'h0: tick = 1'b1;
      2'h1: tick = div_reg[0];
      2'h2: tick = &div_reg[1:0];
      2'h3: tick = &div_reg;
    endcase
  end
endmodule // tcrb_prescale
`default_nettype wire

// ### sim/timer_capture_register_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_capture_register_bank_tb_top;
  logic clk, nrst, ce, reg_wr, demod_pin_a, demod_pin_b, lowbat_sense;
  logic wide_cap_strobe, port_bit, int_five_enable;
  logic pin_out, narrow_out, int_five_req, timeout_irq, capture_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, common_ctl, wide_ctl, rd, v;
  logic [15:0] wide_cap_value, wide_hold;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int caps = 0;
  int n, c0;

  tcrb_bank dut
  (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .demod_pin_a(demod_pin_a),
    .demod_pin_b(demod_pin_b),
    .lowbat_sense(lowbat_sense),
    .wide_cap_value(wide_cap_value),
    .wide_cap_strobe(wide_cap_strobe),
    .wide_hold(wide_hold),
    .common_ctl(common_ctl),
    .wide_ctl(wide_ctl),
    .port_bit(port_bit),
    .pin_out(pin_out),
    .narrow_out(narrow_out),
    .int_five_enable(int_five_enable),
    .int_five_req(int_five_req),
    .timeout_irq(timeout_irq),
    .capture_irq(capture_irq)
  );

  // ==========================================
  // Clock, watchdog, capture counting
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (capture_irq === 1'b1)
      caps <= caps + 1;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  // ==========================================
  // Tasks
  task stop_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task rdv(input logic [3:0] a);
    reg_addr = a;
    cyc(1);
    rd = reg_rdata;
  endtask

  task wait_tog(output int k);
    logic s;
    s = narrow_out;
    k = 0;
    while (narrow_out === s && k < 300)
    begin
      cyc(1);
      k++;
    end
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    demod_pin_a = 1'b0;
    demod_pin_b = 1'b0;
    lowbat_sense = 1'b0;
    wide_cap_value = 16'h0000;
    wide_cap_strobe = 1'b0;
    port_bit = 1'b0;
    int_five_enable = 1'b0;
    cyc(10);
    nrst = 1'b1;
    // Reset values of every offset
    for (int a = 0; a < 16; a++)
    begin
      rdv(a[3:0]);
      chk($sformatf("reset value at %h", a), 16'h0000, {8'h00, rd});
    end
    // Writable and read-only bytes
    for (int a = 1; a < 16; a++)
    begin
      v = 8'h5a ^ {4'h0, a[3:0]};
      wr(a[3:0], v);
      rdv(a[3:0]);
      if (!(a inside {1, 2, 4, 5, 6, 7}))
        v = 8'h00;
      chk($sformatf("byte at %h", a), {8'h00, v}, {8'h00, rd});
    end
    chk("wide_hold", 16'h5d5c, wide_hold);
    chk("common_ctl", 16'h005b, {8'h00, common_ctl});
    chk("wide_ctl", 16'h0058, {8'h00, wide_ctl});
    wr(4'h1, 8'h00);
    // Low battery enable and flag
    wr(4'hc, 8'hff);
    cyc(4000);
    rdv(4'hc);
    chk("lowbat enabled", 16'h0001, {8'h00, rd});
    lowbat_sense = 1'b1;
    int_five_enable = 1'b1;
    cyc(6);
    rdv(4'hc);
    chk("lowbat flag", 16'h0003, {8'h00, rd});
    chk("int_five_req", 16'h0001, {15'h0000, int_five_req});
    int_five_enable = 1'b0;
    cyc(2);
    chk("int_five_req masked", 16'h0000, {15'h0000, int_five_req});
    wr(4'hc, 8'h02);
    cyc(6);
    rdv(4'hc);
    chk("lowbat disabled", 16'h0000, {8'h00, rd});
    lowbat_sense = 1'b0;
    // Pin routing with port bit
    port_bit = 1'b1;
    cyc(2);
    chk("pin_out port", 16'h0001, {15'h0000, pin_out});
    port_bit = 1'b0;
    cyc(2);
    chk("pin_out port low", 16'h0000, {15'h0000, pin_out});
    // Modulo-N period for each prescale
    wr(4'h4, 8'h03);
    wr(4'h5, 8'h03);
    wr(4'h0, 8'h20);
    for (int p = 0; p < 4; p++)
    begin
      wr(4'h0, 8'h82 | (p[7:0] << 3));
      rdv(4'h0);
      chk("run bit", 16'h0001, {15'h0000, rd[7]});
      wait_tog(n);
      wait_tog(n);
      chk($sformatf("period div %0d", p), 16'h0004 << p, n[15:0]);
      wr(4'h0, 8'h02);
      rdv(4'h0);
      chk("stopped flag kept", 16'h0022, {8'h00, rd});
      chk("timeout_irq", 16'h0001, {15'h0000, timeout_irq});
      wr(4'h0, 8'h22);
      rdv(4'h0);
      chk("flag cleared", 16'h0002, {8'h00, rd});
      chk("timeout_irq off", 16'h0000, {15'h0000, timeout_irq});
    end
    // Single pass without interrupt mask
    wr(4'h0, 8'hc0);
    rd = 8'h80;
    for (int k = 0; k < 60 && rd[7] === 1'b1; k++)
      rdv(4'h0);
    chk("single pass end", 16'h0060, {8'h00, rd});
    chk("timeout_irq unmasked", 16'h0000, {15'h0000, timeout_irq});
    wr(4'h0, 8'h20);
    // Timer level routed to pin
    port_bit = 1'b1;
    wr(4'h0, 8'h01);
    cyc(1);
    chk("narrow_out after pass", 16'h0000, {15'h0000, narrow_out});
    chk("pin_out timer", 16'h0000, {15'h0000, pin_out});
    wr(4'h0, 8'h00);
    port_bit = 1'b0;
    // Wide capture bytes
    wide_cap_value = 16'hbeef;
    wide_cap_strobe = 1'b1;
    cyc(1);
    wide_cap_strobe = 1'b0;
    wr(4'h8, 8'h00);
    rdv(4'h8);
    chk("wide capture low", 16'h00ef, {8'h00, rd});
    rdv(4'h9);
    chk("wide capture high", 16'h00be, {8'h00, rd});
    // Demodulation captures on both edges
    wr(4'h1, 8'ha0);
    wr(4'h0, 8'h84);
    cyc(4);
    c0 = caps;
    demod_pin_a = 1'b1;
    cyc(20);
    demod_pin_a = 1'b0;
    cyc(12);
    demod_pin_a = 1'b1;
    cyc(8);
    chk("capture pulses", 16'h0003, 16'(caps - c0));
    rdv(4'hb);
    chk("high capture", 16'h0001, {15'h0000, (rd >= 8'h12 && rd <= 8'h16)});
    rdv(4'ha);
    chk("low capture", 16'h0001, {15'h0000, (rd >= 8'h0a && rd <= 8'h0e)});
    // Clock enable low freezes all state
    v = rd;
    c0 = caps;
    ce = 1'b0;
    demod_pin_a = 1'b0;
    rdv(4'hb);
    cyc(8);
    chk("frozen read", {8'h00, v}, {8'h00, reg_rdata});
    chk("frozen captures", 16'h0000, 16'(caps - c0));
    ce = 1'b1;
    cyc(6);
    chk("capture after thaw", 16'h0001, 16'(caps - c0));
    stop_test();
  end
endmodule // timer_capture_register_bank_tb_top
`default_nettype wire
